//--- tkd_defines.svh
// constants for the touch key detect and run mode block
`ifndef TKD_DEFINES_SVH
`define TKD_DEFINES_SVH
`define TKD_CLK_MHZ 40
`define TKD_BURST_CYCLES 8'h40
`define TKD_PHASE_CLKS 4'h4
`define TKD_FAST_GAP_US 1000
`define TKD_FAST_GAP_CLKS (`TKD_FAST_GAP_US * `TKD_CLK_MHZ)
`define TKD_LP_GAP_MS 80
`define TKD_LP_GAP_CLKS (`TKD_LP_GAP_MS * 1000 * `TKD_CLK_MHZ)
`define TKD_THRESH 16'h000a
`define TKD_HYST 16'h0002
`define TKD_DI_LIMIT 3'h4
`define TKD_MAX_ON_BURSTS 16'h02ee
`define TKD_DRIFT_BURSTS 8'h10
`define TKD_PIN_IDLE 4'ha
`endif

//--- tkd_pkg.sv
// types for the touch key detect block
package tkd_pkg;
   typedef enum logic [3:0] {
      TKD_ST_CAL = 4'h1,
      TKD_ST_BURST = 4'h2,
      TKD_ST_EVAL = 4'h4,
      TKD_ST_WAIT = 4'h8
   } tkd_state_t;
endpackage : tkd_pkg

//--- tkd_burst_if.sv
// interface between sequencer and burst engine
`timescale 1ns/1ps
interface tkd_burst_if;
   logic start;
   logic done;
   logic [15:0] count;
   modport ctrl (output start, input done, input count);
   modport engine (input start, output done, output count);
endinterface : tkd_burst_if

//--- tkd_burst.sv
// charge-transfer burst engine: pulses the sense pins and counts transfers
`timescale 1ns/1ps
`include "tkd_defines.svh"
module tkd_burst (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // sequencer side
   tkd_burst_if.engine bus,
   // sense pins
   output logic sense_key_pin_o,
   output logic sense_key_pin_oe_n,
   output logic sense_cap_pin_o,
   output logic sense_cap_pin_oe_n,
   input wire logic sense_cap_pin_i
);
   logic [7:0] cyc_reg;
   logic [3:0] ph_reg;
   logic busy_reg;
   logic [15:0] acc_reg;
   logic done_reg;
   wire ph_end = (ph_reg == `TKD_PHASE_CLKS - 4'h1);
   wire last_cyc = (cyc_reg == `TKD_BURST_CYCLES - 8'h01);
   // phases 0 and 1 charge key while cap floats, phases 2 and 3 drive cap low; cap read at end of phase 3
   wire charge_ph = busy_reg && (ph_reg < 4'h2);
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cyc_reg <= 8'h00;
         ph_reg <= 4'h0;
         busy_reg <= 1'b0;
         acc_reg <= 16'h0000;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         if (bus.start && !busy_reg)
         begin
            busy_reg <= 1'b1;
            cyc_reg <= 8'h00;
            ph_reg <= 4'h0;
            acc_reg <= 16'h0000;
         end
         else if (busy_reg)
         begin
            ph_reg <= ph_end ? 4'h0 : ph_reg + 4'h1;
            if (ph_end)
            begin
               // repeated transfers; count those that leave the cap below trip
               acc_reg <= acc_reg + {15'h0000, ~sense_cap_pin_i};
               cyc_reg <= cyc_reg + 8'h01;
               if (last_cyc)
               begin
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
               end
            end
         end
      end
   end
   assign bus.done = done_reg;
   assign bus.count = acc_reg;
   assign sense_key_pin_o = charge_ph;
   assign sense_key_pin_oe_n = ~busy_reg;
   assign sense_cap_pin_o = 1'b0;
   assign sense_cap_pin_oe_n = charge_ph || !busy_reg;
endmodule : tkd_burst

//--- tkd_touch_key.sv
// touch key sequencer: run mode, detection, consensus filter and output
`timescale 1ns/1ps
`include "tkd_defines.svh"
module tkd_touch_key #(
   parameter int FAST_GAP_CLKS = `TKD_FAST_GAP_CLKS,
   parameter int LP_GAP_CLKS = `TKD_LP_GAP_CLKS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // mode input
   input wire logic mode_sync_i,
   // sense pins
   output logic sense_key_pin_o,
   output logic sense_key_pin_oe_n,
   output logic sense_cap_pin_o,
   output logic sense_cap_pin_oe_n,
   input wire logic sense_cap_pin_i,
   // detect and mode outputs
   output logic detect_o,
   output logic fast_mode_o
);
   tkd_burst_if bif ();
   tkd_pkg::tkd_state_t state_reg, state_next;
   logic [31:0] gap_reg;
   logic [15:0] ref_reg;
   logic [2:0] consensus_counter;
   logic det_reg;
   logic out_reg;
   logic fast_reg;
   logic low_power_sleep_mode;
   logic [15:0] on_reg;
   logic [7:0] drift_reg;
   logic start_reg;
   logic key_px_o, key_px_oe_n, cap_px_o, cap_px_oe_n;

   tkd_burst u_burst (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .bus(bif.engine),
      .sense_key_pin_o(key_px_o),
      .sense_key_pin_oe_n(key_px_oe_n),
      .sense_cap_pin_o(cap_px_o),
      .sense_cap_pin_oe_n(cap_px_oe_n),
      .sense_cap_pin_i(sense_cap_pin_i)
   );
   assign bif.start = start_reg;

   // state decodes shared by the sequencer and the filter
   function automatic logic tkd_in_state(input tkd_pkg::tkd_state_t cur, input tkd_pkg::tkd_state_t want);
      tkd_in_state = (cur == want);
   endfunction : tkd_in_state
   wire in_cal = tkd_in_state(state_reg, tkd_pkg::TKD_ST_CAL);
   wire in_eval = tkd_in_state(state_reg, tkd_pkg::TKD_ST_EVAL);
   wire in_wait = tkd_in_state(state_reg, tkd_pkg::TKD_ST_WAIT);
   wire cal_done = in_cal && bif.done;
   wire gap_zero = in_wait && (gap_reg == 32'h0);

   // touch loads the key so fewer transfers stay below trip: delta is ref minus count
   wire [15:0] cnt = bif.count;
   wire [15:0] delta = (ref_reg > cnt) ? ref_reg - cnt : 16'h0000;
   // hysteresis: after a hit, hold until delta falls two below threshold
   wire hit_on = (delta >= `TKD_THRESH);
   wire hit_hold = (delta > `TKD_THRESH - `TKD_HYST);
   wire hit = det_reg ? hit_hold : hit_on;
   wire confirm = (consensus_counter == `TKD_DI_LIMIT - 3'h1) && hit;
   wire max_on = out_reg && (on_reg == `TKD_MAX_ON_BURSTS);
   // resolving is any nonzero counter with output still low
   wire resolving = (consensus_counter != 3'h0) && !out_reg;
   // high selects fast, low selects low-power unless a detection is resolving; sync pulses not supported
   wire want_fast = mode_sync_i || resolving;
   // the gap after a first hit is already short: judge this evaluation, not the old counter
   wire resolve_now = in_eval && hit && !confirm && !out_reg;
   wire gap_fast = mode_sync_i || resolve_now;
   wire [31:0] gap_len = gap_fast ? FAST_GAP_CLKS : LP_GAP_CLKS;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         tkd_pkg::TKD_ST_CAL:
         begin
            if (bif.done)
               state_next = tkd_pkg::TKD_ST_WAIT;
         end
         tkd_pkg::TKD_ST_BURST:
         begin
            if (bif.done)
               state_next = tkd_pkg::TKD_ST_EVAL;
         end
         tkd_pkg::TKD_ST_EVAL:
         begin
            // an output held past the on-duration limit forces a full recalibration
            if (max_on)
               state_next = tkd_pkg::TKD_ST_CAL;
            else
               state_next = tkd_pkg::TKD_ST_WAIT;
         end
         tkd_pkg::TKD_ST_WAIT:
         begin
            if (gap_zero)
               state_next = tkd_pkg::TKD_ST_BURST;
         end
         default: state_next = tkd_pkg::TKD_ST_CAL;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= tkd_pkg::TKD_ST_CAL;
         start_reg <= 1'b1;
         gap_reg <= 32'h0;
      end
      else
      begin
         state_reg <= state_next;
         start_reg <= (state_next != state_reg) &&
            (state_next == tkd_pkg::TKD_ST_BURST || state_next == tkd_pkg::TKD_ST_CAL);
         if (in_eval || in_cal)
            gap_reg <= gap_len - 32'h1;
         else if (gap_reg != 32'h0)
            gap_reg <= gap_reg - 32'h1;
      end
   end

   // filter next values; the registers below load them once per evaluated burst
   wire [2:0] counter_step = (consensus_counter != `TKD_DI_LIMIT) ? consensus_counter + 3'h1 : consensus_counter;
   wire [2:0] counter_next = hit ? counter_step : 3'h0;
   // output held by hysteresis, dropped by a miss or the on-duration limit
   wire out_next = confirm || (out_reg && hit && !max_on);
   wire [15:0] on_next = out_reg ? on_reg + 16'h0001 : 16'h0000;
   // slow drift tracking only while nothing is detected; a touch must not be learned away
   wire drift_idle = !hit && (consensus_counter == 3'h0);
   wire drift_due = (drift_reg == `TKD_DRIFT_BURSTS);
   wire [15:0] ref_up = ref_reg + 16'h0001;
   wire [15:0] ref_down = ref_reg - 16'h0001;
   wire [15:0] ref_drift = (cnt > ref_reg) ? ref_up : ((cnt < ref_reg) ? ref_down : ref_reg);
   wire [7:0] drift_next = drift_due ? 8'h00 : drift_reg + 8'h01;

   // consensus counter and hit memory
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || cal_done)
      begin
         consensus_counter <= 3'h0;
         det_reg <= 1'b0;
      end
      else if (in_eval)
      begin
         consensus_counter <= counter_next;
         det_reg <= hit;
      end
   end

   // detect output and its on-duration timer; recalibration drops the output
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || cal_done)
      begin
         out_reg <= 1'b0;
         on_reg <= 16'h0000;
      end
      else if (in_eval)
      begin
         out_reg <= out_next;
         on_reg <= on_next;
      end
   end

   // reference: taken whole at calibration, then nudged one count per drift period
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ref_reg <= 16'h0000;
         drift_reg <= 8'h00;
      end
      else if (cal_done)
         ref_reg <= cnt;
      else if (in_eval && drift_idle)
      begin
         drift_reg <= drift_next;
         if (drift_due)
            ref_reg <= ref_drift;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         detect_o <= 1'b0;
         fast_reg <= 1'b0;
      end
      else
      begin
         detect_o <= out_reg;
         fast_reg <= want_fast;
      end
   end
   assign low_power_sleep_mode = !fast_reg;
   assign fast_mode_o = !low_power_sleep_mode;

   // pin drive re-timed so every pin comes straight from a flop, one clock behind the engine
   wire [3:0] pin_px = {cap_px_oe_n, cap_px_o, key_px_oe_n, key_px_o};
   localparam logic [3:0] PIN_IDLE = `TKD_PIN_IDLE;
   logic pin_reg [0:3];
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_pin
         // released pins sit with enable high and level low
         always_ff @(posedge sys_clk)
         begin
            if (!rst_n)
               pin_reg[gi] <= PIN_IDLE[gi];
            else
               pin_reg[gi] <= pin_px[gi];
         end
      end
   endgenerate
   assign sense_key_pin_o = pin_reg[0];
   assign sense_key_pin_oe_n = pin_reg[1];
   assign sense_cap_pin_o = pin_reg[2];
   assign sense_cap_pin_oe_n = pin_reg[3];
endmodule : tkd_touch_key

//--- tkd_touch_key_props.sv
// checker for the touch key detect block
`timescale 1ns/1ps
module tkd_touch_key_props #(
   parameter int FAST_GAP_CLKS = 50,
   parameter int LP_GAP_CLKS = 200
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic mode_sync_i,
   input wire logic sense_key_pin_o,
   input wire logic sense_key_pin_oe_n,
   input wire logic sense_cap_pin_o,
   input wire logic sense_cap_pin_oe_n,
   input wire logic sense_cap_pin_i,
   input wire logic detect_o,
   input wire logic fast_mode_o
);
   int idle_cnt;
   int hi_cnt;
   // hi_cnt saturates so a long run cannot wrap
   always_ff @(posedge sys_clk)
   begin
      idle_cnt <= (!rst_n || !sense_key_pin_oe_n) ? 0 : idle_cnt + 1;
      hi_cnt <= (!rst_n || !mode_sync_i) ? 0 : hi_cnt + int'(hi_cnt < 4000);
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   rst_out_a: assert property (disable iff (1'b0) !rst_n |=> !detect_o && !fast_mode_o)
      else $error("outputs not low in reset");
   rst_pin_a: assert property (disable iff (1'b0) !rst_n |=> sense_key_pin_oe_n && sense_cap_pin_oe_n)
      else $error("pins driven in reset");
   key_drv_a: assert property (!sense_key_pin_oe_n && sense_key_pin_o |-> sense_cap_pin_oe_n)
      else $error("key charged while cap dumps");
   cap_drv_a: assert property (!sense_cap_pin_oe_n |-> !sense_cap_pin_o)
      else $error("cap pin driven high");
   mode_fast_a: assert property (hi_cnt == LP_GAP_CLKS + 400 |-> fast_mode_o)
      else $error("no fast mode with mode high");
   fast_fall_a: assert property ($fell(fast_mode_o) && $past(rst_n) |-> !$past(mode_sync_i))
      else $error("fast mode left with mode high");
   det_rise_a: assert property ($rose(detect_o) |-> $past(sense_key_pin_oe_n) && $past(sense_key_pin_oe_n, 2))
      else $error("detect rose inside a burst");
   gap_min_a: assert property ($fell(sense_key_pin_oe_n) && idle_cnt > 8 |-> idle_cnt >= FAST_GAP_CLKS)
      else $error("gap too short");
   gap_fast_a: assert property ($fell(sense_key_pin_oe_n) && idle_cnt > 8 && hi_cnt > idle_cnt + 300
      |-> idle_cnt <= FAST_GAP_CLKS + 16)
      else $error("fast gap too long");
   det_c: cover property ($rose(detect_o));
   fast_c: cover property ($rose(fast_mode_o));
   lp_c: cover property ($fell(sense_key_pin_oe_n) && idle_cnt > LP_GAP_CLKS);
endmodule : tkd_touch_key_props
bind tkd_touch_key tkd_touch_key_props #(.FAST_GAP_CLKS(FAST_GAP_CLKS), .LP_GAP_CLKS(LP_GAP_CLKS)) i_props (
   .sys_clk(sys_clk), .rst_n(rst_n), .mode_sync_i(mode_sync_i), .sense_key_pin_o(sense_key_pin_o),
   .sense_key_pin_oe_n(sense_key_pin_oe_n), .sense_cap_pin_o(sense_cap_pin_o),
   .sense_cap_pin_oe_n(sense_cap_pin_oe_n), .sense_cap_pin_i(sense_cap_pin_i),
   .detect_o(detect_o), .fast_mode_o(fast_mode_o));

//--- tkd_key_model.sv
// behavioural key electrode model with burst tracking
`timescale 1ns/1ps
module tkd_key_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // stimulus
   input wire logic touch,
   // sense pins
   input wire logic key_oe_n,
   output logic cap_i,
   // burst tracking
   output int bursts,
   output int gap
);
   int idle;
   // a touch holds the cap above the trip level for the whole burst
   assign cap_i = touch;
   // the key enable stays low for a whole burst; 8 idle clocks mark its end
   always @(posedge sys_clk)
   begin
      idle <= (!rst_n || !key_oe_n) ? 0 : idle + 1;
      bursts <= !rst_n ? 0 : bursts + int'(key_oe_n && idle == 8);
      if (!key_oe_n && idle > 8)
         gap <= idle;
   end
endmodule : tkd_key_model

//--- test_tkd_touch_key.sv
// testbench for the touch key detect block
`timescale 1ns/1ps
module test_tkd_touch_key;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic mode_sync_i = 1'b1;
   logic touch = 1'b0;
   logic key_o, key_oe_n, cap_o, cap_oe_n, cap_i, detect_o, fast_mode_o;
   int bursts, gap, b0;
   int num_errors = 0;
   int tests_run = 0;
   always #12.5 sys_clk = ~sys_clk;
   tkd_touch_key #(.FAST_GAP_CLKS(50), .LP_GAP_CLKS(200)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .mode_sync_i(mode_sync_i), .sense_key_pin_o(key_o), .sense_key_pin_oe_n(key_oe_n),
      .sense_cap_pin_o(cap_o), .sense_cap_pin_oe_n(cap_oe_n), .sense_cap_pin_i(cap_i),
      .detect_o(detect_o), .fast_mode_o(fast_mode_o));
   tkd_key_model i_key (.sys_clk(sys_clk), .rst_n(rst_n), .touch(touch), .key_oe_n(key_oe_n),
      .cap_i(cap_i), .bursts(bursts), .gap(gap));
   task automatic chk_bit(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %0t: got %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_rng(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi)
      begin
         num_errors++;
         $display("Error %0t: gap %0d out of %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_rng
   task automatic wait_b(input int n);
      b0 = bursts;
      while (bursts < b0 + n)
         @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : wait_b
   task automatic set_touch(input logic v);
      @(posedge sys_clk);
      touch <= v;
   endtask : set_touch
   task automatic fast_test();
      wait_b(2);
      chk_bit(fast_mode_o, 1'b1);
      chk_rng(gap, 50, 70);
      set_touch(1'b1);
      wait_b(3);
      chk_bit(detect_o, 1'b0);
      wait_b(1);
      chk_bit(detect_o, 1'b1);
      set_touch(1'b0);
      wait_b(1);
      chk_bit(detect_o, 1'b0);
      $display("fast_test done");
   endtask : fast_test
   task automatic spur_test();
      // two runs of three hits must not add up to four
      repeat (2)
      begin
         set_touch(1'b1);
         wait_b(3);
         chk_bit(detect_o, 1'b0);
         set_touch(1'b0);
         wait_b(1);
         chk_bit(detect_o, 1'b0);
      end
      $display("spur_test done");
   endtask : spur_test
   task automatic lp_test();
      @(posedge sys_clk);
      mode_sync_i <= 1'b0;
      wait_b(2);
      chk_bit(fast_mode_o, 1'b0);
      chk_rng(gap, 200, 220);
      set_touch(1'b1);
      wait_b(2);
      chk_bit(fast_mode_o, 1'b1);
      chk_rng(gap, 50, 70);
      wait_b(2);
      chk_bit(detect_o, 1'b1);
      set_touch(1'b0);
      wait_b(2);
      chk_bit(detect_o, 1'b0);
      chk_bit(fast_mode_o, 1'b0);
      $display("lp_test done");
   endtask : lp_test
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (4)
         @(posedge sys_clk);
      chk_bit(detect_o, 1'b0);
      chk_bit(key_oe_n, 1'b1);
      rst_n <= 1'b1;
      fast_test();
      spur_test();
      lp_test();
      close_out();
   end
   initial
   begin
      repeat (40000)
         @(posedge sys_clk);
      num_errors++;
      $display("Error %0t: watchdog expired", $time);
      close_out();
   end
endmodule : test_tkd_touch_key
